// *** tpio_pkg.sv ***
// Purpose: Shared constants for the timer pin I/O-control decode block
// Assumes: 32-bit Avalon-MM data, byte addresses, aligned word accesses
// Notes:   Offsets are byte addresses; each register sits in the low bits
package tpio_pkg;
    // Register byte offsets
    localparam logic [4:0] TPIO_OFS_CHAN0_LOW_IO_CONTROL = 5'h00;
    localparam logic [4:0] TPIO_OFS_CHAN1_IO_CONTROL     = 5'h04;
    localparam logic [4:0] TPIO_OFS_CHAN0_MODE_REG       = 5'h08;
    localparam logic [4:0] TPIO_OFS_CHAN0_GENERAL_REG_D  = 5'h0c;
    localparam logic [4:0] TPIO_OFS_CHAN1_GENERAL_REG_B  = 5'h10;
    localparam logic [4:0] TPIO_OFS_STATUS               = 5'h14;
    // Field positions
    localparam int TPIO_CODE_HI_LSB  = 4;
    localparam int TPIO_MODE_BFB_BIT = 0;
    localparam int TPIO_ST_D_CAP     = 0;
    localparam int TPIO_ST_D_MATCH   = 1;
    localparam int TPIO_ST_B_CAP     = 2;
    localparam int TPIO_ST_B_MATCH   = 3;
    localparam int TPIO_ST_D_PIN     = 4;
    localparam int TPIO_ST_B_PIN     = 5;
    // Reset values
    localparam logic [7:0] TPIO_RST_IO_CONTROL = 8'h00;
    localparam logic       TPIO_RST_BFB        = 1'b0;
    localparam logic [3:0] TPIO_RST_FLAGS      = 4'h0;
    localparam logic       TPIO_RST_PIN        = 1'b0;
    localparam logic       TPIO_RST_HELD_LOW   = 1'b1;
    // Code decode values
    localparam logic [1:0] TPIO_ACT_HOLD   = 2'h0;
    localparam logic [1:0] TPIO_ACT_DRIVE0 = 2'h1;
    localparam logic [1:0] TPIO_ACT_DRIVE1 = 2'h2;
    localparam logic [1:0] TPIO_ACT_TOGGLE = 2'h3;
    localparam logic [3:0] TPIO_CODE_RISE  = 4'h8;
    localparam logic [3:0] TPIO_CODE_FALL  = 4'h9;
endpackage

// *** tpio_sync3.sv ***
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to i_core_clk
// Notes:   Level changes only when stages two and three agree
module tpio_sync3 (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_reset_n,
    // Pin side
    input  wire logic i_async,
    // Core side
    output logic      o_level
);
    import tpio_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } tpio_sync_t;

    tpio_sync_t r_reg;
    tpio_sync_t r_next;

    always_comb begin
        r_next    = r_reg;
        r_next.s1 = i_async;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        if (r_reg.s2 == r_reg.s3) begin
            r_next.level = r_reg.s3;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_level = r_reg.level;

    a_sync_agree_only: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (r_reg.s2 != r_reg.s3) |=> $stable(r_reg.level))
        else $error("sync level moved while stages disagreed");
endmodule // tpio_sync3

// *** tpio_reg_unit.sv ***
// Purpose: One general register with its four-bit I/O-control decode
// Assumes: Count, running and cascade inputs come from the core clock
// Notes:   Compare acts only while counting, so a stopped counter never retoggles
module tpio_reg_unit #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_reset_n,
    // Control
    input  wire logic         i_standby,
    input  wire logic [3:0]   i_code,
    input  wire logic         i_code_wr,
    input  wire logic         i_buffer_mode,
    input  wire logic         i_running,
    // Counter and events
    input  wire logic [W-1:0] i_count,
    input  wire logic         i_pin_level,
    input  wire logic         i_cascade_evt,
    // Software access to the general register
    input  wire logic         i_gr_wr,
    input  wire logic [W-1:0] i_gr_wdata,
    output logic [W-1:0]      o_gr,
    // Pin and events
    output logic              o_pin,
    output logic              o_pin_oe,
    output logic              o_capture,
    output logic              o_match
);
    import tpio_pkg::*;

    typedef struct packed {
        logic [W-1:0] gr;
        logic         pin;
        logic         oe;
        logic         held_low;
        logic         lvl_prev;
        logic         cap_evt;
        logic         cmp_evt;
    } tpio_unit_t;

    tpio_unit_t r_reg;
    tpio_unit_t r_next;
    logic       active;
    logic       is_cmp;
    logic       rise;
    logic       fall;
    logic       cap_hit;
    logic       cmp_hit;

    always_comb begin
        r_next         = r_reg;
        r_next.cap_evt = 1'b0;
        r_next.cmp_evt = 1'b0;
        r_next.lvl_prev = i_pin_level;
        active  = !i_buffer_mode;
        is_cmp  = !i_code[3];
        rise    = i_pin_level && !r_reg.lvl_prev;
        fall    = !i_pin_level && r_reg.lvl_prev;
        cap_hit = 1'b0;
        cmp_hit = active && is_cmp && i_running && (i_count == r_reg.gr);
        if (active && !is_cmp) begin
            if (i_code[2]) begin
                cap_hit = i_cascade_evt;
            end else if (i_code[1]) begin
                cap_hit = rise || fall;
            end else if (i_code == TPIO_CODE_FALL) begin
                cap_hit = fall;
            end else begin
                cap_hit = rise;
            end
        end
        if (i_gr_wr) begin
            r_next.gr = i_gr_wdata;
        end
        // Capture beats a software write in the same cycle
        if (cap_hit) begin
            r_next.gr      = i_count;
            r_next.cap_evt = 1'b1;
        end
        if (active && is_cmp && !i_running && i_code[1:0] != TPIO_ACT_HOLD) begin
            r_next.pin = i_code[2];
        end
        if (cmp_hit) begin
            r_next.cmp_evt = 1'b1;
            case (i_code[1:0])
                TPIO_ACT_DRIVE0: r_next.pin = 1'b0;
                TPIO_ACT_DRIVE1: r_next.pin = 1'b1;
                TPIO_ACT_TOGGLE: r_next.pin = !r_reg.pin;
                default:         r_next.pin = r_reg.pin;
            endcase
        end
        if (i_code_wr) begin
            r_next.held_low = 1'b0;
        end
        if (i_standby) begin
            r_next.held_low = 1'b1;
        end
        // Low until software sets the code after reset or standby
        if (r_next.held_low) begin
            r_next.pin = 1'b0;
        end
        r_next.oe = r_next.held_low || (active && is_cmp);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            r_reg          <= '0;
            r_reg.pin      <= TPIO_RST_PIN;
            r_reg.held_low <= TPIO_RST_HELD_LOW;
            r_reg.oe       <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_gr      = r_reg.gr;
    assign o_pin     = r_reg.pin;
    assign o_pin_oe  = r_reg.oe;
    assign o_capture = r_reg.cap_evt;
    assign o_match   = r_reg.cmp_evt;

    a_held_low_pin: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        r_reg.held_low |-> (!r_reg.pin && r_reg.oe))
        else $error("pin not low while awaiting code");
    a_toggle_on_match: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (cmp_hit && i_code[1:0] == TPIO_ACT_TOGGLE && !i_code_wr && !i_standby && !r_reg.held_low)
        |=> (r_reg.pin != $past(r_reg.pin)) && r_reg.cmp_evt)
        else $error("toggle missing on compare match");
    a_capture_value: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (active && i_code == TPIO_CODE_RISE && rise) |=> (r_reg.cap_evt && r_reg.gr == $past(i_count)))
        else $error("rising edge capture missing");
    a_buffer_silent: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $past(i_buffer_mode) |-> !(r_reg.cap_evt || r_reg.cmp_evt))
        else $error("event while register in buffer mode");
    a_initial_level: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (active && !i_code[3] && !i_running && i_code[1:0] != TPIO_ACT_HOLD && !r_next.held_low)
        |=> r_reg.pin == $past(i_code[2]))
        else $error("initial level not applied while stopped");
endmodule // tpio_reg_unit

// *** tpio_decode.sv ***
// Purpose: Decode of I/O-control codes for channel 0 register D and channel 1 register B
// Assumes: Counters and register C events live outside; pins pass three sync stages
// Notes:   Avalon-MM slave with one wait state on every access
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
module tpio_decode #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_reset_n,
    // Avalon-MM slave
    input  wire logic [4:0]   i_avs_address,
    input  wire logic         i_avs_read,
    input  wire logic         i_avs_write,
    input  wire logic [31:0]  i_avs_writedata,
    output logic [31:0]       o_avs_readdata,
    output logic              o_avs_waitrequest,
    // Timer core
    input  wire logic         i_standby,
    input  wire logic         i_chan0_running,
    input  wire logic         i_chan1_running,
    input  wire logic [W-1:0] i_chan0_counter,
    input  wire logic [W-1:0] i_chan1_counter,
    input  wire logic         i_chan1_count_step,
    input  wire logic         i_chan0_reg_c_event,
    // Pins
    input  wire logic         i_chan0_pin_d,
    output logic              o_chan0_pin_d,
    output logic              o_chan0_pin_d_oe,
    input  wire logic         i_chan1_pin_b,
    output logic              o_chan1_pin_b,
    output logic              o_chan1_pin_b_oe
);
    import tpio_pkg::*;

    typedef struct packed {
        logic [7:0]  ctl0;
        logic [7:0]  ctl1;
        logic        bfb;
        logic [3:0]  flags;
        logic        wait_n;
        logic [31:0] rdata;
    } tpio_top_t;

    tpio_top_t    r_reg;
    tpio_top_t    r_next;
    logic         take;
    logic         wr_ctl0;
    logic         wr_ctl1;
    logic         wr_grd;
    logic         wr_grb;
    logic [31:0]  rd_mux;
    logic [3:0]   flag_set;
    logic [3:0]   flag_clr;
    logic         lvl_d;
    logic         lvl_b;
    logic [W-1:0] grd;
    logic [W-1:0] grb;
    logic         pin_d;
    logic         pin_d_oe;
    logic         pin_b;
    logic         pin_b_oe;
    logic         cap_d;
    logic         cap_b;
    logic         match_d;
    logic         match_b;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    tpio_sync3 u_sync_d (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    (i_chan0_pin_d),
        .o_level    (lvl_d)
    );

    tpio_sync3 u_sync_b (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    (i_chan1_pin_b),
        .o_level    (lvl_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register D of channel 0 and register B of channel 1

    tpio_reg_unit #(.W(W)) u_reg_d (
        .i_core_clk    (i_core_clk),
        .i_reset_n     (i_reset_n),
        .i_standby     (i_standby),
        .i_code        (r_reg.ctl0[TPIO_CODE_HI_LSB +: 4]),
        .i_code_wr     (wr_ctl0),
        .i_buffer_mode (r_reg.bfb),
        .i_running     (i_chan0_running),
        .i_count       (i_chan0_counter),
        .i_pin_level   (lvl_d),
        .i_cascade_evt (i_chan1_count_step),
        .i_gr_wr       (wr_grd),
        .i_gr_wdata    (i_avs_writedata[W-1:0]),
        .o_gr          (grd),
        .o_pin         (pin_d),
        .o_pin_oe      (pin_d_oe),
        .o_capture     (cap_d),
        .o_match       (match_d)
    );

    // Buffer mode only pairs register D with channel 0, so B is never blocked
    tpio_reg_unit #(.W(W)) u_reg_b (
        .i_core_clk    (i_core_clk),
        .i_reset_n     (i_reset_n),
        .i_standby     (i_standby),
        .i_code        (r_reg.ctl1[TPIO_CODE_HI_LSB +: 4]),
        .i_code_wr     (wr_ctl1),
        .i_buffer_mode (1'b0),
        .i_running     (i_chan1_running),
        .i_count       (i_chan1_counter),
        .i_pin_level   (lvl_b),
        .i_cascade_evt (i_chan0_reg_c_event),
        .i_gr_wr       (wr_grb),
        .i_gr_wdata    (i_avs_writedata[W-1:0]),
        .o_gr          (grb),
        .o_pin         (pin_b),
        .o_pin_oe      (pin_b_oe),
        .o_capture     (cap_b),
        .o_match       (match_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave and status

    always_comb begin
        r_next   = r_reg;
        // Accept only at the edge where waitrequest is already low
        take     = (i_avs_read || i_avs_write) && r_reg.wait_n;
        wr_ctl0  = take && i_avs_write && i_avs_address == TPIO_OFS_CHAN0_LOW_IO_CONTROL;
        wr_ctl1  = take && i_avs_write && i_avs_address == TPIO_OFS_CHAN1_IO_CONTROL;
        wr_grd   = take && i_avs_write && i_avs_address == TPIO_OFS_CHAN0_GENERAL_REG_D;
        wr_grb   = take && i_avs_write && i_avs_address == TPIO_OFS_CHAN1_GENERAL_REG_B;
        flag_clr = 4'h0;
        flag_set = 4'h0;
        rd_mux   = 32'h0000_0000;
        case (i_avs_address)
            TPIO_OFS_CHAN0_LOW_IO_CONTROL: rd_mux[7:0] = r_reg.ctl0;
            TPIO_OFS_CHAN1_IO_CONTROL:     rd_mux[7:0] = r_reg.ctl1;
            TPIO_OFS_CHAN0_MODE_REG:       rd_mux[TPIO_MODE_BFB_BIT] = r_reg.bfb;
            TPIO_OFS_CHAN0_GENERAL_REG_D:  rd_mux[W-1:0] = grd;
            TPIO_OFS_CHAN1_GENERAL_REG_B:  rd_mux[W-1:0] = grb;
            TPIO_OFS_STATUS: begin
                rd_mux[3:0]           = r_reg.flags;
                rd_mux[TPIO_ST_D_PIN] = pin_d;
                rd_mux[TPIO_ST_B_PIN] = pin_b;
            end
            default:                       rd_mux = 32'h0000_0000;
        endcase
        // Wait state drops for one cycle per request, then rises again
        r_next.wait_n = (i_avs_read || i_avs_write) && !r_reg.wait_n;
        if ((i_avs_read || i_avs_write) && !r_reg.wait_n) begin
            r_next.rdata = rd_mux;
        end
        if (wr_ctl0) begin
            r_next.ctl0 = i_avs_writedata[7:0];
        end
        if (wr_ctl1) begin
            r_next.ctl1 = i_avs_writedata[7:0];
        end
        if (take && i_avs_write && i_avs_address == TPIO_OFS_CHAN0_MODE_REG) begin
            r_next.bfb = i_avs_writedata[TPIO_MODE_BFB_BIT];
        end
        if (take && i_avs_write && i_avs_address == TPIO_OFS_STATUS) begin
            flag_clr = i_avs_writedata[3:0];
        end
        flag_set[TPIO_ST_D_CAP]   = cap_d;
        flag_set[TPIO_ST_D_MATCH] = match_d;
        flag_set[TPIO_ST_B_CAP]   = cap_b;
        flag_set[TPIO_ST_B_MATCH] = match_b;
        // A new event in the clearing cycle is kept
        r_next.flags = (r_reg.flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            r_reg        <= '0;
            r_reg.ctl0   <= TPIO_RST_IO_CONTROL;
            r_reg.ctl1   <= TPIO_RST_IO_CONTROL;
            r_reg.bfb    <= TPIO_RST_BFB;
            r_reg.flags  <= TPIO_RST_FLAGS;
        end else begin
            r_reg <= r_next;
        end
    end

    // wait_n holds the inverse of waitrequest so the flop reset is all zero
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !r_next.wait_n;
        end
    end

    assign o_avs_readdata   = r_reg.rdata;
    assign o_chan0_pin_d    = pin_d;
    assign o_chan0_pin_d_oe = pin_d_oe;
    assign o_chan1_pin_b    = pin_b;
    assign o_chan1_pin_b_oe = pin_b_oe;

    a_wait_one_cycle: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("waitrequest did not drop for exactly one cycle");
    a_reset_low_pin: assert property (@(posedge i_core_clk)
        !i_reset_n |=> (!o_chan0_pin_d && !o_chan1_pin_b && o_chan0_pin_d_oe))
        else $error("pins not driven low after reset");
    a_drive_one_match: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_chan1_running && r_reg.ctl1[7:4] == 4'h2 && i_chan1_counter == grb && !wr_ctl1
         && !i_standby && !u_reg_b.r_reg.held_low) |=> (o_chan1_pin_b && match_b))
        else $error("drive one on match missing");
    a_drive_zero_match: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_chan0_running && !r_reg.bfb && r_reg.ctl0[7:4] == 4'h5 && i_chan0_counter == grd)
        |=> !o_chan0_pin_d)
        else $error("drive zero on match missing");
    a_cascade_step: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (!r_reg.bfb && r_reg.ctl0[7:6] == 2'h3 && i_chan1_count_step)
        |=> (cap_d && grd == $past(i_chan0_counter)) ##1 r_reg.flags[TPIO_ST_D_CAP])
        else $error("cascade capture on count step missing");
    a_c_event_capture: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (r_reg.ctl1[7:6] == 2'h3 && i_chan0_reg_c_event) |=> cap_b)
        else $error("capture on register C event missing");
    a_falling_capture: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (r_reg.ctl1[7:4] == TPIO_CODE_FALL && $fell(lvl_b)) |-> ##1 cap_b)
        else $error("falling edge capture missing");
    a_both_edges: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (r_reg.ctl1[7:5] == 3'h5 && $changed(lvl_b)) |=> cap_b)
        else $error("both edge capture missing");
    a_flag_set_wins: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        cap_d |=> r_reg.flags[TPIO_ST_D_CAP])
        else $error("capture flag lost");
endmodule // tpio_decode

// *** tpio_far_model.sv ***
// Purpose: Model of the timer counters and neighbour channel events
// Assumes: Bench commands arrive on core clock edges
// Notes:   Step pulse coincides with each count of channel 1
module tpio_far_model #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic    i_core_clk,
    input  wire logic    i_reset_n,
    // Bench commands
    input  wire logic    i_run0,
    input  wire logic    i_run1,
    input  wire logic    i_clr0,
    input  wire logic    i_fire_c,
    // Timer core side
    output logic [W-1:0] o_cnt0,
    output logic [W-1:0] o_cnt1,
    output logic         o_step1,
    output logic         o_c_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_cnt0  <= '0;
            o_cnt1  <= '0;
            o_step1 <= 1'b0;
            o_c_evt <= 1'b0;
        end else begin
            o_cnt0  <= i_clr0 ? '0 : o_cnt0 + W'(i_run0);
            o_cnt1  <= o_cnt1 + W'(i_run1);
            o_step1 <= i_run1;
            // One pulse per register C match or capture
            o_c_evt <= i_fire_c;
        end
    end
endmodule // tpio_far_model

// *** tb_top.sv ***
// Purpose: Self-checking bench for tpio_decode
// Assumes: One wait state per bus access; pins seen 3-4 cycles late
// Notes:   Compare and capture codes run from tables; cascade and buffer cases by hand after them
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tpio_pkg::*;
    logic        clk, rst_n, rd, wr, stby, run0, run1, clr0, fire_c, ext_d, ext_b;
    logic [4:0]  adr;
    logic [31:0] wd, rdat, v;
    logic        wreq, step1, c_evt, pd, pd_oe, pb, pb_oe;
    logic [15:0] cnt0, cnt1;
    int          n_fail, checks_done;
    // Wire level: design drives while enabled, else the outside world
    wire pin_d_w = pd_oe ? pd : ext_d;
    wire pin_b_w = pb_oe ? pb : ext_b;
    // Rows: code, initial level, level after match
    localparam logic [5:0] CMP [8] = '{6'h00, 6'h04, 6'h1b, 6'h13, 6'h16, 6'h09, 6'h0d, 6'h1e};
    // Rows: code, new pin level, capture expected
    localparam logic [5:0] CAP [7] = '{6'h23, 6'h20, 6'h26, 6'h25, 6'h2b, 6'h29, 6'h2f};
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
    ////////////////////////////////////////////////////////////////
    tpio_decode #(.W(16)) uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_standby(stby), .i_chan0_running(run0),
        .i_chan1_running(run1), .i_chan0_counter(cnt0), .i_chan1_counter(cnt1),
        .i_chan1_count_step(step1), .i_chan0_reg_c_event(c_evt), .i_chan0_pin_d(pin_d_w),
        .o_chan0_pin_d(pd), .o_chan0_pin_d_oe(pd_oe), .i_chan1_pin_b(pin_b_w),
        .o_chan1_pin_b(pb), .o_chan1_pin_b_oe(pb_oe));
    tpio_far_model #(.W(16)) far (.i_core_clk(clk), .i_reset_n(rst_n), .i_run0(run0),
        .i_run1(run1), .i_clr0(clr0), .i_fire_c(fire_c), .o_cnt0(cnt0), .o_cnt1(cnt1),
        .o_step1(step1), .o_c_evt(c_evt));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= ~w;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        v  = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic end_sim;
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Whole run needs about 330 cycles; allow about eighteen times that
    initial begin
        #120000;
        n_fail++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, rd, wr, stby, run0, run1, fire_c, ext_d, ext_b} = '0;
        clr0 = 1'b1;
        adr = '0;
        wd = '0;
        n_fail = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("pins after reset", 4'h5, {pd, pd_oe, pb, pb_oe})
        bus(0, TPIO_OFS_CHAN0_LOW_IO_CONTROL, '0);
        `CHK("ctrl0 reset", 32'h0, v)
        bus(0, 5'h18, '0);
        `CHK("unmapped read", 32'h0, v)
        bus(1, TPIO_OFS_CHAN0_GENERAL_REG_D, 32'h5);
        for (int i = 0; i < 8; i++) begin
            run0 <= 1'b0;
            clr0 <= 1'b1;
            bus(1, TPIO_OFS_CHAN0_LOW_IO_CONTROL, {24'h0, CMP[i][5:2], 4'h0});
            clr0 <= 1'b0;
            repeat (2) @(posedge clk);
            `CHK("pin_d initial", CMP[i][1], pd)
            run0 <= 1'b1;
            repeat (12) @(posedge clk);
            `CHK("pin_d after match", CMP[i][0], pd)
        end
        run0 <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            bus(1, TPIO_OFS_CHAN0_LOW_IO_CONTROL, {24'h0, CAP[i][5:2], 4'h0});
            bus(1, TPIO_OFS_STATUS, 32'hf);
            ext_d <= CAP[i][1];
            repeat (8) @(posedge clk);
            bus(0, TPIO_OFS_STATUS, '0);
            `CHK("pin_d capture", CAP[i][0], v[TPIO_ST_D_CAP])
        end
        bus(0, TPIO_OFS_CHAN0_GENERAL_REG_D, '0);
        `CHK("captured count", {16'h0, cnt0}, v)
        bus(1, TPIO_OFS_CHAN0_LOW_IO_CONTROL, 32'hc0);
        bus(1, TPIO_OFS_STATUS, 32'hf);
        run1 <= 1'b1;
        repeat (4) @(posedge clk);
        run1 <= 1'b0;
        bus(0, TPIO_OFS_STATUS, '0);
        `CHK("cascade step capture", 1'b1, v[TPIO_ST_D_CAP])
        bus(1, TPIO_OFS_STATUS, 32'hf);
        repeat (4) @(posedge clk);
        bus(0, TPIO_OFS_STATUS, '0);
        `CHK("no step no capture", 1'b0, v[TPIO_ST_D_CAP])
        bus(1, TPIO_OFS_CHAN1_IO_CONTROL, 32'hc0);
        bus(1, TPIO_OFS_STATUS, 32'hf);
        fire_c <= 1'b1;
        @(posedge clk);
        fire_c <= 1'b0;
        repeat (3) @(posedge clk);
        bus(0, TPIO_OFS_STATUS, '0);
        `CHK("reg C cascade", 1'b1, v[TPIO_ST_B_CAP])
        bus(1, TPIO_OFS_CHAN0_MODE_REG, 32'h1);
        bus(1, TPIO_OFS_STATUS, 32'hf);
        run1 <= 1'b1;
        repeat (4) @(posedge clk);
        run1 <= 1'b0;
        bus(0, TPIO_OFS_STATUS, '0);
        `CHK("buffer mode capture", 1'b0, v[TPIO_ST_D_CAP])
        `CHK("buffer mode oe", 1'b0, pd_oe)
        stby <= 1'b1;
        @(posedge clk);
        stby <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("pins after standby", 4'h5, {pd, pd_oe, pb, pb_oe})
        end_sim();
    end
endmodule // tb_top
